// ===== verilog/epl_latch_accum.sv
/*
  energy pulse latch and accumulation modes: per-phase energy accumulators
  and hour registers, mode-conditioned pulse datapath sums, latching on
  falling converter edges, sum sign tracking, status and interrupt pin.
  assumes the converter outputs, stage events and power samples come from
  logic on core_clk; the register port is a plain strobe port.
*/
// Decided for this implementation: strobed register access.
// Contract
// - power type select: 000 tot act, 001 tot react, 010 app, 011/100 fund
// - falling latch edge copies selected accumulators to hour regs, clears
// - all three phases latch regardless of phase include bits
// - 8-bit latch cycle count gives falling edges between latches
// - pulse mode bits 14..12 enable latching per output, reset cleared
// - latching works even with the output pin disabled
// - active mode bits 1..0 govern hour regs and pulse path 000/011
// - active mode 00: signed accumulation in both paths
// - active mode 01: hour regs drop negatives, pulse path stays signed
// - active mode 10 behaves as 00
// - active mode 11: absolute accumulation in both paths
// - reactive mode bits 3..2 govern hour regs and pulse path 001/100
// - reactive mode 00 signed; 01 behaves as 00
// - reactive mode 10: negate reactive when active negative above no-load
// - reactive mode 11: absolute accumulation in both paths
// - check sum sign at each first-stage threshold event; readable
// - reverse-sum status bits 18/13/9 set at next falling pulse edge
// - sum sign bits 8/7/3 update with status; 1 means negative
// - masked status drives interrupt pin low; write 1 clears it
// - three no-load detectors: total, fundamental, apparent
`timescale 1ns/1ps

module epl_latch_accum (
  input wire logic core_clk,
  input wire logic nrst,
  input wire epl_pkg::epl_bus_s bus_req,
  output logic [31:0] rdata,
  input wire logic sample_valid,
  input wire epl_pkg::epl_pow_t power_in [epl_pkg::NTYPE][epl_pkg::NPH],
  input wire logic [2:0] conv_out_n,
  input wire logic [2:0] stage_evt,
  input wire logic [2:0] stage_neg,
  output logic [2:0] energy_pulse_output_n,
  output epl_pkg::epl_sum_t pulse_power [epl_pkg::NCH],
  output logic [8:0] noload_phase,
  output logic first_interrupt_pin_n
);
  import epl_pkg::*;

  // conditions one phase power for accumulation
  function automatic epl_con_t cond_power(
    input epl_pow_t p,
    input logic [1:0] mode,
    input logic is_react,
    input logic act_neg
  );
    epl_con_t pe;
    epl_con_t r;
    pe = epl_con_t'(p);
    r = pe;
    if (!is_react)
    begin
      if (mode == ACC_POS_ONLY && p < 0)
        r = '0;
      else if (mode == ACC_ABSOLUTE && p < 0)
        r = -pe;
    end
    else
    begin
      if (mode == ACC_SIGN_ADJ && act_neg)
        r = -pe;
      else if (mode == ACC_ABSOLUTE && p < 0)
        r = -pe;
    end
    return r;
  endfunction

  // magnitude below a nonzero threshold
  function automatic logic below_thr(input epl_pow_t p, input logic [15:0] t);
    epl_con_t a;
    a = (p < 0) ? -epl_con_t'(p) : epl_con_t'(p);
    return (t != 16'h0000) && (a < epl_con_t'({1'b0, t}));
  endfunction

  // software registers
  logic [7:0] acc_mode_reg, acc_mode_next;
  logic [7:0] cyc_reg, cyc_next;
  logic [14:0] pmode_reg, pmode_next;
  logic [8:0] cmode_reg, cmode_next;
  logic [15:0] nl_act_reg, nl_act_next;
  logic [15:0] nl_app_reg, nl_app_next;
  logic [2:0] mask_reg, mask_next;
  logic [2:0] status_reg, status_next;
  logic [2:0] sign_reg, sign_next;
  logic [31:0] rdata_next;
  // energy state
  epl_acc_t acc_reg [NTYPE][NPH];
  epl_acc_t acc_next [NTYPE][NPH];
  epl_acc_t hour_reg [NTYPE][NPH];
  epl_acc_t hour_next [NTYPE][NPH];
  epl_sum_t psum_next [NCH];
  // pulse side state
  logic [2:0] conv_prev_reg;
  logic [7:0] cnt_reg [NCH];
  logic [7:0] cnt_next [NCH];
  logic [2:0] last_neg_reg, last_neg_next;
  logic [2:0] pend_reg, pend_next;
  logic [2:0] pend_neg_reg, pend_neg_next;
  logic [2:0] pin_next;
  logic irq_next;
  logic [8:0] nl_next;
  // combinational helpers
  logic [1:0] wacc, vacc, wacc_pulse;
  logic [2:0] fall;
  logic [2:0] latch_ch;
  logic [NTYPE-1:0] latch_type;
  logic [NPH-1:0] nl_grp [3];
  epl_con_t ch [NTYPE][NPH];
  epl_con_t cp [NTYPE][NPH];

  // mode fields and no-load detection
  always_comb
  begin
    wacc = acc_mode_reg[WACC_LSB +: 2];
    vacc = acc_mode_reg[VACC_LSB +: 2];
    // reserved codes fold onto signed; pulse path never drops negatives
    if (wacc == ACC_SIGN_ADJ)
      wacc = ACC_SIGNED;
    if (vacc == ACC_POS_ONLY)
      vacc = ACC_SIGNED;
    wacc_pulse = (wacc == ACC_POS_ONLY) ? ACC_SIGNED : wacc;
    for (int p = 0; p < NPH; p++)
    begin
      nl_grp[0][p] = below_thr(power_in[SEL_TOT_ACT][p], nl_act_reg) &&
        below_thr(power_in[SEL_TOT_REACT][p], nl_act_reg);
      nl_grp[1][p] = below_thr(power_in[SEL_FUND_ACT][p], nl_act_reg) &&
        below_thr(power_in[SEL_FUND_REACT][p], nl_act_reg);
      nl_grp[2][p] = below_thr(power_in[SEL_APPARENT][p], nl_app_reg);
    end
    nl_next = {nl_grp[2], nl_grp[1], nl_grp[0]};
  end

  // conditioned contributions for the hour and pulse datapaths
  always_comb
  begin
    for (int t = 0; t < NTYPE; t++)
    begin
      for (int p = 0; p < NPH; p++)
      begin
        logic react;
        logic aneg;
        logic nl;
        int at;
        int g;
        react = (t == SEL_TOT_REACT) || (t == SEL_FUND_REACT);
        at = (t == SEL_FUND_REACT) ? SEL_FUND_ACT : SEL_TOT_ACT;
        g = (t == SEL_APPARENT) ? 2 : ((t >= SEL_FUND_ACT) ? 1 : 0);
        nl = nl_grp[g][p];
        // active under the no-load threshold counts as zero, not negative
        aneg = (power_in[at][p] < 0) &&
          !below_thr(power_in[at][p], nl_act_reg);
        if (nl)
        begin
          ch[t][p] = '0;
          cp[t][p] = '0;
        end
        else if (t == SEL_APPARENT)
        begin
          ch[t][p] = epl_con_t'(power_in[t][p]);
          cp[t][p] = ch[t][p];
        end
        else
        begin
          ch[t][p] = cond_power(power_in[t][p], react ? vacc : wacc,
            react, aneg);
          cp[t][p] = cond_power(power_in[t][p], react ? vacc : wacc_pulse,
            react, aneg);
        end
      end
    end
  end

  // falling edge counting toward the latch cycle count
  always_comb
  begin
    logic [7:0] cyc_eff;
    cyc_eff = (cyc_reg == 8'h00) ? 8'h01 : cyc_reg;
    fall = conv_prev_reg & ~conv_out_n;
    for (int c = 0; c < NCH; c++)
    begin
      latch_ch[c] = 1'b0;
      cnt_next[c] = cnt_reg[c];
      // disable bit is not consulted: latching runs with the pin off
      if (!pmode_reg[LATCH_LSB + c])
        cnt_next[c] = 8'h00;
      else if (fall[c])
      begin
        if ({1'b0, cnt_reg[c]} + 9'h001 >= {1'b0, cyc_eff})
        begin
          latch_ch[c] = 1'b1;
          cnt_next[c] = 8'h00;
        end
        else
          cnt_next[c] = cnt_reg[c] + 8'h01;
      end
    end
    for (int t = 0; t < NTYPE; t++)
    begin
      latch_type[t] = 1'b0;
      for (int c = 0; c < NCH; c++)
        if (latch_ch[c] && pmode_reg[c*SEL_W +: SEL_W] == 3'(t))
          latch_type[t] = 1'b1;
    end
  end

  // accumulators, hour registers and pulse datapath sums
  always_comb
  begin
    for (int t = 0; t < NTYPE; t++)
    begin
      for (int p = 0; p < NPH; p++)
      begin
        // every phase of the type latches; include bits are ignored here
        hour_next[t][p] = latch_type[t] ? acc_reg[t][p] :
          hour_reg[t][p];
        acc_next[t][p] = latch_type[t] ? '0 : acc_reg[t][p];
        if (sample_valid)
          acc_next[t][p] = acc_next[t][p] + epl_acc_t'(ch[t][p]);
      end
    end
    for (int c = 0; c < NCH; c++)
    begin
      logic [2:0] sel;
      sel = pmode_reg[c*SEL_W +: SEL_W];
      psum_next[c] = '0;
      if (sel <= SEL_FUND_REACT)
        for (int p = 0; p < NPH; p++)
          if (cmode_reg[c*NPH + p])
            psum_next[c] = psum_next[c] + epl_sum_t'(cp[sel][p]);
    end
  end

  // sum sign tracking, status and sign register, bus writes
  always_comb
  begin
    acc_mode_next = acc_mode_reg;
    cyc_next = cyc_reg;
    pmode_next = pmode_reg;
    cmode_next = cmode_reg;
    nl_act_next = nl_act_reg;
    nl_app_next = nl_app_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    sign_next = sign_reg;
    last_neg_next = last_neg_reg;
    pend_next = pend_reg;
    pend_neg_next = pend_neg_reg;
    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        ADDR_ACC_MODE: acc_mode_next = bus_req.wdata[7:0];
        // a change here racing a falling edge may miscount once
        ADDR_LATCH_CYC: cyc_next = bus_req.wdata[7:0];
        ADDR_PULSE_MODE: pmode_next = bus_req.wdata[14:0];
        ADDR_COMP_MODE: cmode_next = bus_req.wdata[8:0];
        ADDR_NL_ACT: nl_act_next = bus_req.wdata[15:0];
        ADDR_NL_APP: nl_app_next = bus_req.wdata[15:0];
        ADDR_FIRST_MASK_REGISTER:
          for (int c = 0; c < NCH; c++)
            mask_next[c] = bus_req.wdata[REV_POS[c]];
        ADDR_FIRST_STATUS_REGISTER:
          for (int c = 0; c < NCH; c++)
            if (bus_req.wdata[REV_POS[c]])
              status_next[c] = 1'b0;
        default: ;
      endcase
    end
    for (int c = 0; c < NCH; c++)
    begin
      // a pending change is reported on the next falling edge; set wins
      if (fall[c] && pend_reg[c])
      begin
        status_next[c] = 1'b1;
        sign_next[c] = pend_neg_reg[c];
        pend_next[c] = 1'b0;
      end
      if (stage_evt[c] && stage_neg[c] != last_neg_next[c])
      begin
        pend_next[c] = 1'b1;
        pend_neg_next[c] = stage_neg[c];
        last_neg_next[c] = stage_neg[c];
      end
    end
  end

  // read mux, pins and interrupt
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        ADDR_ACC_MODE: rdata_next = {24'h00_0000, acc_mode_reg};
        ADDR_LATCH_CYC: rdata_next = {24'h00_0000, cyc_reg};
        ADDR_PULSE_MODE: rdata_next = {17'h0_0000, pmode_reg};
        ADDR_COMP_MODE: rdata_next = {23'h00_0000, cmode_reg};
        ADDR_NL_ACT: rdata_next = {16'h0000, nl_act_reg};
        ADDR_NL_APP: rdata_next = {16'h0000, nl_app_reg};
        ADDR_FIRST_MASK_REGISTER:
          for (int c = 0; c < NCH; c++)
            rdata_next[REV_POS[c]] = mask_reg[c];
        ADDR_FIRST_STATUS_REGISTER:
          for (int c = 0; c < NCH; c++)
            rdata_next[REV_POS[c]] = status_reg[c];
        ADDR_SUM_SIGN:
          for (int c = 0; c < NCH; c++)
            rdata_next[SIGN_POS[c]] = sign_reg[c];
        default:
          for (int t = 0; t < NTYPE; t++)
            for (int p = 0; p < NPH; p++)
              if (bus_req.addr == ADDR_HOUR_BASE + 16'(t*NPH + p))
                rdata_next = hour_reg[t][p];
      endcase
    end
    for (int c = 0; c < NCH; c++)
      pin_next[c] = pmode_reg[DIS_LSB + c] ? 1'b1 : conv_out_n[c];
    // pin moves with status at the same edge, so a clear releases it promptly
    irq_next = ~|(status_next & mask_next);
  end

  // state registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_mode_reg <= RST_ACC_MODE;
      cyc_reg <= RST_LATCH_CYC;
      pmode_reg <= RST_PULSE_MODE;
      cmode_reg <= RST_COMP_MODE;
      nl_act_reg <= RST_NL_THR;
      nl_app_reg <= RST_NL_THR;
      mask_reg <= 3'h0;
      status_reg <= 3'h0;
      sign_reg <= 3'h0;
      last_neg_reg <= 3'h0;
      pend_reg <= 3'h0;
      pend_neg_reg <= 3'h0;
      conv_prev_reg <= 3'h7;
      rdata <= 32'h0000_0000;
      energy_pulse_output_n <= 3'h7;
      first_interrupt_pin_n <= 1'b1;
      noload_phase <= 9'h000;
      for (int c = 0; c < NCH; c++)
      begin
        cnt_reg[c] <= 8'h00;
        pulse_power[c] <= '0;
      end
      for (int t = 0; t < NTYPE; t++)
        for (int p = 0; p < NPH; p++)
        begin
          acc_reg[t][p] <= '0;
          hour_reg[t][p] <= '0;
        end
    end
    else
    begin
      acc_mode_reg <= acc_mode_next;
      cyc_reg <= cyc_next;
      pmode_reg <= pmode_next;
      cmode_reg <= cmode_next;
      nl_act_reg <= nl_act_next;
      nl_app_reg <= nl_app_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      sign_reg <= sign_next;
      last_neg_reg <= last_neg_next;
      pend_reg <= pend_next;
      pend_neg_reg <= pend_neg_next;
      conv_prev_reg <= conv_out_n;
      rdata <= rdata_next;
      energy_pulse_output_n <= pin_next;
      first_interrupt_pin_n <= irq_next;
      noload_phase <= nl_next;
      for (int c = 0; c < NCH; c++)
      begin
        cnt_reg[c] <= cnt_next[c];
        pulse_power[c] <= psum_next[c];
      end
      for (int t = 0; t < NTYPE; t++)
        for (int p = 0; p < NPH; p++)
        begin
          acc_reg[t][p] <= acc_next[t][p];
          hour_reg[t][p] <= hour_next[t][p];
        end
    end
  end

endmodule

// ===== pkg/epl_pkg.sv
/*
  shared constants and types for the energy pulse latch and accumulation
  mode block: register offsets, field positions, reset values, carriers.
  assumes a 16-bit register address space and a 32-bit data word.
*/
package epl_pkg;

  // datapath widths
  localparam int PW = 24;
  localparam int ACW = 32;
  localparam int NTYPE = 5;
  localparam int NPH = 3;
  localparam int NCH = 3;

  typedef logic signed [PW-1:0] epl_pow_t;
  typedef logic signed [PW:0] epl_con_t;
  typedef logic signed [PW+2:0] epl_sum_t;
  typedef logic signed [ACW-1:0] epl_acc_t;

  // register bus request, one cycle per access
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } epl_bus_s;

  // register offsets
  localparam logic [15:0] ADDR_ACC_MODE = 16'hE701;
  localparam logic [15:0] ADDR_LATCH_CYC = 16'hE705;
  localparam logic [15:0] ADDR_SUM_SIGN = 16'hE617;
  localparam logic [15:0] ADDR_PULSE_MODE = 16'hE610;
  localparam logic [15:0] ADDR_COMP_MODE = 16'hE60E;
  localparam logic [15:0] ADDR_FIRST_STATUS_REGISTER = 16'hE502;
  localparam logic [15:0] ADDR_FIRST_MASK_REGISTER = 16'hE50A;
  localparam logic [15:0] ADDR_NL_ACT = 16'hE908;
  localparam logic [15:0] ADDR_NL_APP = 16'hE90A;
  // hour registers: base + type * 3 + phase
  localparam logic [15:0] ADDR_HOUR_BASE = 16'hE400;

  // power type select codes
  localparam logic [2:0] SEL_TOT_ACT = 3'h0;
  localparam logic [2:0] SEL_TOT_REACT = 3'h1;
  localparam logic [2:0] SEL_APPARENT = 3'h2;
  localparam logic [2:0] SEL_FUND_ACT = 3'h3;
  localparam logic [2:0] SEL_FUND_REACT = 3'h4;

  // accumulation mode codes
  localparam logic [1:0] ACC_SIGNED = 2'h0;
  localparam logic [1:0] ACC_POS_ONLY = 2'h1;
  localparam logic [1:0] ACC_SIGN_ADJ = 2'h2;
  localparam logic [1:0] ACC_ABSOLUTE = 2'h3;

  // field positions
  localparam int WACC_LSB = 0;
  localparam int VACC_LSB = 2;
  localparam int SEL_W = 3;
  localparam int DIS_LSB = 9;
  localparam int LATCH_LSB = 12;
  localparam int REV_POS [NCH] = '{9, 13, 18};
  localparam int SIGN_POS [NCH] = '{3, 7, 8};

  // values after reset
  localparam logic [7:0] RST_ACC_MODE = 8'h00;
  localparam logic [7:0] RST_LATCH_CYC = 8'h01;
  localparam logic [14:0] RST_PULSE_MODE = 15'h0E88;
  localparam logic [8:0] RST_COMP_MODE = 9'h1FF;
  localparam logic [15:0] RST_NL_THR = 16'h0000;

endpackage

// ===== tb/epl_latch_accum_properties.sv
/*
  port checks for the pulse latch block: pin gating, register read
  widths, interrupt pin timing against pulse edges and status clears.
  assumes it is bound to epl_latch_accum and sees only its ports.
*/
`timescale 1ns/1ps

module epl_latch_accum_properties (
  input wire logic core_clk,
  input wire logic nrst,
  input wire epl_pkg::epl_bus_s bus_req,
  input wire logic [31:0] rdata,
  input wire logic [2:0] conv_out_n,
  input wire logic [2:0] energy_pulse_output_n,
  input wire logic first_interrupt_pin_n
);
  import epl_pkg::*;
  logic [2:0] dis_reg;
  logic [2:0] dis_next;

  // shadow of the pin disable bits, so gating is judged from the bus
  always_comb
  begin
    dis_next = dis_reg;
    if (bus_req.wr && bus_req.addr == ADDR_PULSE_MODE)
      dis_next = bus_req.wdata[11:9];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      dis_reg <= 3'h7;
    else
      dis_reg <= dis_next;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // both old and new disable values agree, so register timing is moot
  pin_off_a: assert property (
    (dis_reg & $past(dis_reg) & ~energy_pulse_output_n) == 3'h0)
    else $error("disabled pulse pin went low");
  pin_follow_a: assert property (
    (~dis_reg & ~$past(dis_reg)
      & (energy_pulse_output_n ^ $past(conv_out_n))) == 3'h0)
    else $error("enabled pulse pin not one cycle behind");
  // status and pin move at the same edge that sees the fall
  irq_set_a: assert property (
    $fell(first_interrupt_pin_n) |->
      |(~$past(conv_out_n) & $past(conv_out_n, 2)))
    else $error("interrupt fell without a pulse edge");
  irq_clr_a: assert property (
    $rose(first_interrupt_pin_n) |->
      $past(bus_req.wr) && $past(bus_req.addr) == ADDR_FIRST_STATUS_REGISTER)
    else $error("interrupt rose without a status write");
  irq_hold_a: assert property (
    !first_interrupt_pin_n && !bus_req.wr && !$past(bus_req.wr)
      |=> !first_interrupt_pin_n)
    else $error("interrupt released without a write");
  sign_read_a: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == ADDR_SUM_SIGN
      |-> (rdata & 32'hFFFF_FE77) == 32'h0)
    else $error("sign read shows bits outside the sum signs");
  cyc_width_a: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == ADDR_LATCH_CYC
      |-> rdata[31:8] == 24'h00_0000)
    else $error("latch cycle count wider than eight bits");
  mode_width_a: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == ADDR_ACC_MODE
      |-> rdata[31:4] == 28'h000_0000)
    else $error("accumulation mode read wider than four bits");

  cover property ($fell(first_interrupt_pin_n));
  cover property ($rose(first_interrupt_pin_n));
  cover property ($past(bus_req.rd) && rdata != 32'h0);
endmodule

bind epl_latch_accum epl_latch_accum_properties
  epl_latch_accum_properties_i (
  .core_clk,
  .nrst,
  .bus_req,
  .rdata,
  .conv_out_n,
  .energy_pulse_output_n,
  .first_interrupt_pin_n
);

// ===== tb/epl_cal_model.sv
/*
  calibration equipment model: counts falling edges on each pulse pin.
  assumes the pins are synchronous to core_clk and idle high.
*/
`timescale 1ns/1ps

module epl_cal_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] pin_n,
  output logic [7:0] pulse_cnt [3]
);
  logic [2:0] last_reg;

  // the counter only sees the pin, so a gated pin must count nothing
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      last_reg <= 3'h7;
      pulse_cnt <= '{default: 8'h00};
    end
    else
    begin
      last_reg <= pin_n;
      for (int i = 0; i < 3; i++)
        if (last_reg[i] && !pin_n[i])
          pulse_cnt[i] <= pulse_cnt[i] + 8'h01;
    end
  end
endmodule

// ===== tb/tb_energy_pulse_latch_accum_modes.sv
/*
  testbench for the pulse latch block: defaults, accumulation modes,
  latch cycle count, select codes, sum sign status and interrupt pin.
  assumes the design, its bound checker and the calibration model.
*/
`timescale 1ns/1ps

module tb_energy_pulse_latch_accum_modes;
  import epl_pkg::*;
  typedef struct {logic [15:0] a; logic [31:0] v;} epl_reg_s;
  typedef struct {logic [7:0] mode; int hw; int hq; int p0; int p1;}
    epl_row_s;
  logic core_clk;
  logic nrst;
  epl_bus_s bus_req;
  logic [31:0] rdata;
  logic sample_valid;
  epl_pow_t power_in [NTYPE][NPH];
  logic [2:0] conv_out_n;
  logic [2:0] stage_evt;
  logic [2:0] stage_neg;
  logic [2:0] energy_pulse_output_n;
  epl_sum_t pulse_power [NCH];
  logic [8:0] noload_phase;
  logic first_interrupt_pin_n;
  logic [7:0] pulse_cnt [3];
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n2 = 0;
  int se [3] = '{9, -2, 0};
  epl_reg_s dflt [9] = '{'{ADDR_ACC_MODE, 32'h0},
    '{ADDR_LATCH_CYC, 32'h1}, '{ADDR_PULSE_MODE, 32'h0000_0E88},
    '{ADDR_COMP_MODE, 32'h0000_01FF}, '{ADDR_FIRST_STATUS_REGISTER, 32'h0},
    '{ADDR_FIRST_MASK_REGISTER, 32'h0}, '{ADDR_SUM_SIGN, 32'h0},
    '{ADDR_HOUR_BASE, 32'h0}, '{16'h1234, 32'h0}};
  // phase A act -5, react -7; phase B act +3, four samples a row
  epl_row_s rows [4] = '{'{8'h00, -20, -28, -5, -7},
    '{8'h05, 0, -28, -5, -7}, '{8'h0A, -20, 28, -5, 7},
    '{8'h0F, 20, 28, 5, 7}};

  epl_latch_accum epl_latch_accum_i (.core_clk, .nrst, .bus_req, .rdata,
    .sample_valid, .power_in, .conv_out_n, .stage_evt, .stage_neg,
    .energy_pulse_output_n, .pulse_power, .noload_phase,
    .first_interrupt_pin_n);
  epl_cal_model epl_cal_model_i (.core_clk, .nrst,
    .pin_n(energy_pulse_output_n), .pulse_cnt);

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
  endtask

  // read data stands one cycle only, so look just after the edge
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1 chk($sformatf("reg %h", a), rdata, e);
    @(posedge core_clk);
  endtask

  task automatic fall(input logic [2:0] m);
    conv_out_n <= ~m;
    @(posedge core_clk);
    conv_out_n <= 3'h7;
    @(posedge core_clk);
    n2 += int'(m[1]);
  endtask

  task automatic samp(input int k);
    sample_valid <= 1'b1;
    repeat (k) @(posedge core_clk);
    sample_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic sign_round(input logic [2:0] neg);
    stage_evt <= 3'h7;
    stage_neg <= neg;
    @(posedge core_clk);
    stage_evt <= 3'h0;
    @(posedge core_clk);
    fall(3'h7);
    repeat (2) @(posedge core_clk);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      give_verdict();
    end
  end

  initial
  begin
    nrst = 1'b0;
    bus_req = '0;
    sample_valid = 1'b0;
    power_in = '{default: '0};
    conv_out_n = 3'h7;
    stage_evt = 3'h0;
    stage_neg = 3'h0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    wr(16'h1234, 32'hFFFF_FFFF);
    foreach (dflt[i])
      rd(dflt[i].a, dflt[i].v);
    chk("noload", 32'(noload_phase), 32'h0);
    power_in[0][0] <= epl_pow_t'(-5);
    power_in[0][1] <= epl_pow_t'(3);
    power_in[1][0] <= epl_pow_t'(-7);
    power_in[3][0] <= epl_pow_t'(9);
    power_in[4][0] <= epl_pow_t'(-2);
    // outputs 1 and 2 sum phase A only; pin 1 stays gated off
    wr(ADDR_COMP_MODE, 32'h0000_01C9);
    wr(ADDR_PULSE_MODE, 32'h0000_3A88);
    foreach (rows[i])
    begin
      wr(ADDR_ACC_MODE, {24'h0, rows[i].mode});
      fall(3'h3);
      samp(4);
      chk("pp1", 32'(pulse_power[0]), rows[i].p0);
      chk("pp2", 32'(pulse_power[1]), rows[i].p1);
      fall(3'h3);
      rd(ADDR_HOUR_BASE, rows[i].hw);
      rd(ADDR_HOUR_BASE + 16'h1, 32'h0000_000C);
      rd(ADDR_HOUR_BASE + 16'h3, rows[i].hq);
    end
    wr(ADDR_ACC_MODE, 32'h0);
    wr(ADDR_LATCH_CYC, 32'h0000_0003); // no edge in flight
    fall(3'h3);
    samp(2);
    fall(3'h3);
    samp(2);
    rd(ADDR_HOUR_BASE, 32'h0000_0014);
    fall(3'h3);
    rd(ADDR_HOUR_BASE, 32'hFFFF_FFEC);
    // two edges, then a spell with latching off must restart the count
    fall(3'h3);
    fall(3'h3);
    wr(ADDR_PULSE_MODE, 32'h0000_0A88);
    wr(ADDR_PULSE_MODE, 32'h0000_3A88);
    fall(3'h3);
    rd(ADDR_HOUR_BASE, 32'hFFFF_FFEC);
    foreach (se[i])
    begin
      wr(ADDR_PULSE_MODE, 32'h0000_3A08 | 32'((i + 3) << 6));
      repeat (2) @(posedge core_clk);
      chk("pp3", 32'(pulse_power[2]), se[i]);
    end
    wr(ADDR_FIRST_MASK_REGISTER, 32'h0000_0200);
    sign_round(3'h7);
    rd(ADDR_FIRST_STATUS_REGISTER, 32'h0004_2200);
    rd(ADDR_SUM_SIGN, 32'h0000_0188); // set with status
    chk("irq", 32'(first_interrupt_pin_n), 32'h0);
    wr(ADDR_FIRST_STATUS_REGISTER, 32'h0004_2200);
    repeat (2) @(posedge core_clk);
    chk("irq", 32'(first_interrupt_pin_n), 32'h1);
    wr(ADDR_FIRST_MASK_REGISTER, 32'h0);
    sign_round(3'h0);
    chk("irq", 32'(first_interrupt_pin_n), 32'h1);
    rd(ADDR_FIRST_STATUS_REGISTER, 32'h0004_2200);
    rd(ADDR_SUM_SIGN, 32'h0);
    chk("cnt1", 32'(pulse_cnt[0]), 32'h0);
    chk("cnt2", 32'(pulse_cnt[1]), 32'(n2));
    wr(ADDR_NL_ACT, 32'h0000_0010);
    repeat (4) @(posedge core_clk);
    chk("noload", 32'(noload_phase), 32'h0000_003F);
    wr(ADDR_NL_APP, 32'h0000_0010);
    repeat (2) @(posedge core_clk);
    chk("noload", 32'(noload_phase), 32'h0000_01FF);
    // mid-run reset must drop every setting and flag made above
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("noload", 32'(noload_phase), 32'h0);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(ADDR_FIRST_STATUS_REGISTER, 32'h0);
    rd(ADDR_PULSE_MODE, 32'h0000_0E88);
    give_verdict();
  end
endmodule
